// [fpp_port.v]
// parallel programming command port of the on-chip flash
`timescale 1ns/1ps
`include "fpp_defines.vh"

module fpp_port #(
    parameter ADDR_W       = 17,
    parameter DEPTH        = 131072,
    parameter PROG_CYCLES  = `FPP_PROG_CYCLES,
    parameter ERASE_CYCLES = `FPP_ERASE_CYCLES
) (
    input  wire              clk,
    input  wire              reset_n,
    input  wire              boot_mode_supply_pin,
    input  wire              check_select,
    input  wire              chip_select_n,
    input  wire              output_enable_n,
    input  wire              write_strobe_n,
    input  wire [ADDR_W-1:0] address,
    input  wire [7:0]        data_bus_in,
    output reg  [7:0]        data_bus_out,
    output reg               data_bus_oe_n,
    output reg               busy
);

    localparam [2:0] ST_READ     = 3'd0;
    localparam [2:0] ST_PROG_ARM = 3'd1;
    localparam [2:0] ST_PVERIFY  = 3'd2;
    localparam [2:0] ST_ERASE_AR = 3'd3;
    localparam [2:0] ST_EVERIFY  = 3'd4;
    localparam [2:0] ST_RESET_AR = 3'd5;
    localparam [2:0] ST_IDLE     = 3'd6;

    reg [7:0]        mem [0:DEPTH-1];
    reg [2:0]        mode;
    reg [ADDR_W-1:0] wr_addr;
    reg [ADDR_W-1:0] prog_addr;
    reg [ADDR_W-1:0] verify_addr;
    reg [7:0]        prog_data;
    reg              we_n_d;
    reg [31:0]       op_count;
    reg              prog_run;
    reg              erase_run;
    reg [ADDR_W:0]   erase_idx;
    reg [7:0]        next_out;
    reg              next_oe_n;
    reg [7:0]        protect_byte;

    // read-write needs supply and check_select high
    wire rw_mode   = boot_mode_supply_pin & check_select;
    wire we_fall   = we_n_d & ~write_strobe_n;
    wire we_rise   = ~we_n_d & write_strobe_n;
    // write state: chip select low, output enable high, read-write only
    // read-only mode never accepts a write
    wire wr_ok     = rw_mode & ~chip_select_n & output_enable_n;
    wire cmd_take  = we_rise & wr_ok & ~busy;
    // exactly one protect bit low blocks access
    // both protect bits at zero release it
    wire prot_on   = ~(protect_byte[`FPP_PROTECT_BIT0] == 1'b0 &&
                       protect_byte[`FPP_PROTECT_BIT1] == 1'b0) &
                     (~protect_byte[`FPP_PROTECT_BIT0] | ~protect_byte[`FPP_PROTECT_BIT1]);

    function in_range;
        input [ADDR_W-1:0] a;
        begin
            in_range = ({1'b0, a} < DEPTH);
        end
    endfunction

    // read data chosen by the latest command
    always @* begin
        next_out  = 8'h00;
        next_oe_n = 1'b1;
        // read-only still offers the read state
        if (boot_mode_supply_pin && !chip_select_n && !output_enable_n && write_strobe_n) begin
            next_oe_n = 1'b0;
            case (mode)
                ST_PVERIFY: next_out = prot_on ? 8'h00 : mem[prog_addr];
                ST_EVERIFY: next_out = prot_on ? 8'h00 : mem[verify_addr];
                // read mode returns the addressed content
                ST_READ:    next_out = (prot_on || !in_range(address)) ? 8'h00 : mem[address];
                default:    next_out = 8'h00;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            mode          <= ST_READ;
            we_n_d        <= 1'b1;
            wr_addr       <= {ADDR_W{1'b0}};
            prog_addr     <= {ADDR_W{1'b0}};
            verify_addr   <= {ADDR_W{1'b0}};
            prog_data     <= 8'h00;
            op_count      <= 32'h0;
            prog_run      <= 1'b0;
            erase_run     <= 1'b0;
            erase_idx     <= {(ADDR_W+1){1'b0}};
            data_bus_out  <= 8'h00;
            data_bus_oe_n <= 1'b1;
            busy          <= 1'b0;
            protect_byte  <= 8'hff;
        end else begin
            we_n_d        <= write_strobe_n;
            data_bus_out  <= next_out;
            data_bus_oe_n <= next_oe_n;
            // address on the falling strobe edge
            if (we_fall && wr_ok)
                wr_addr <= address;
            if (prog_run) begin
                if (op_count == 32'h0) begin
                    prog_run <= 1'b0;
                    busy     <= 1'b0;
                    if (in_range(prog_addr) && !prot_on) begin
                        mem[prog_addr] <= prog_data;
                        // shadow of the protect location, avoids reading unknown memory
                        if (prog_addr == `FPP_PROTECT_ADDR)
                            protect_byte <= prog_data;
                    end
                    mode <= ST_IDLE;
                end else
                    op_count <= op_count - 32'h1;
            end
            if (erase_run) begin
                if (erase_idx < DEPTH && !prot_on) begin
                    mem[erase_idx[ADDR_W-1:0]] <= `FPP_ERASED_BYTE;
                    if (erase_idx[ADDR_W-1:0] == `FPP_PROTECT_ADDR)
                        protect_byte <= `FPP_ERASED_BYTE;
                    erase_idx <= erase_idx + 1'b1;
                end
                if (op_count == 32'h0) begin
                    erase_run <= 1'b0;
                    busy      <= 1'b0;
                    mode      <= ST_IDLE;
                end else
                    op_count <= op_count - 32'h1;
            end
            // command or data on the rising strobe edge
            if (cmd_take) begin
                case (mode)
                    ST_PROG_ARM: begin
                        // second cycle holds address and data
                        prog_addr <= wr_addr;
                        prog_data <= data_bus_in;
                        if (!prot_on) begin
                            prog_run <= 1'b1;
                            busy     <= 1'b1;
                            op_count <= PROG_CYCLES - 1;
                        end
                        mode <= ST_IDLE;
                    end
                    ST_ERASE_AR: begin
                        // second erase code starts the erase
                        if (data_bus_in == `FPP_CMD_ERASE && !prot_on) begin
                            erase_run <= 1'b1;
                            busy      <= 1'b1;
                            erase_idx <= {(ADDR_W+1){1'b0}};
                            op_count  <= ERASE_CYCLES - 1;
                        end
                        mode <= ST_IDLE;
                    end
                    ST_RESET_AR: begin
                        // second reset code returns to read
                        mode <= (data_bus_in == `FPP_CMD_RESET) ? ST_READ : ST_IDLE;
                    end
                    default: begin
                        case (data_bus_in)
                            `FPP_CMD_READ:        mode <= ST_READ;
                            `FPP_CMD_PROGRAM:     mode <= ST_PROG_ARM;
                            `FPP_CMD_PROG_VERIFY: mode <= ST_PVERIFY;
                            `FPP_CMD_ERASE:       mode <= ST_ERASE_AR;
                            // verify address from the first cycle
                            `FPP_CMD_ERASE_VERIFY: begin
                                mode        <= ST_EVERIFY;
                                verify_addr <= wr_addr;
                            end
                            `FPP_CMD_RESET:       mode <= ST_RESET_AR;
                            default:              mode <= ST_IDLE;
                        endcase
                    end
                endcase
            end
            // two consecutive reset codes abort a running operation
            if (we_rise && wr_ok && busy && data_bus_in == `FPP_CMD_RESET) begin
                if (mode == ST_RESET_AR) begin
                    prog_run  <= 1'b0;
                    erase_run <= 1'b0;
                    busy      <= 1'b0;
                    mode      <= ST_READ;
                end else
                    mode <= ST_RESET_AR;
            end
        end
    end

endmodule

// [fpp_defines.vh]
// constants for the flash parallel program port
`ifndef FPP_DEFINES_VH
`define FPP_DEFINES_VH

`define FPP_CMD_READ        8'h00
`define FPP_CMD_PROGRAM     8'h40
`define FPP_CMD_PROG_VERIFY 8'hc0
`define FPP_CMD_ERASE       8'h20
`define FPP_CMD_ERASE_VERIFY 8'ha0
`define FPP_CMD_RESET       8'hff
`define FPP_ERASED_BYTE     8'hff
`define FPP_PROTECT_ADDR    17'h0ffff
`define FPP_PROTECT_BIT0    0
`define FPP_PROTECT_BIT1    1
`define FPP_CLK_MHZ         200
`define FPP_PROG_TIME_US    20
`define FPP_ERASE_TIME_MS   20
`define FPP_PROG_CYCLES     (`FPP_PROG_TIME_US * `FPP_CLK_MHZ)
`define FPP_ERASE_CYCLES    (`FPP_ERASE_TIME_MS * 1000 * `FPP_CLK_MHZ)

`endif

// [fpp_port_properties.sv]
// concurrent checks on the parallel program port pins
`timescale 1ns/1ps
module fpp_port_properties #(
    parameter ADDR_W       = 17,
    parameter PROG_CYCLES  = 10,
    parameter ERASE_CYCLES = 300
) (
    input wire              clk,
    input wire              reset_n,
    input wire              boot_mode_supply_pin,
    input wire              check_select,
    input wire              chip_select_n,
    input wire              output_enable_n,
    input wire              write_strobe_n,
    input wire [ADDR_W-1:0] address,
    input wire              data_bus_oe_n,
    input wire              busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_busy_start;
        $rose(busy);
    endsequence
    a_standby_float: assert property (chip_select_n |=> data_bus_oe_n)
        else $error("data bus driven in standby");
    a_disable_float: assert property (!chip_select_n && output_enable_n |=> data_bus_oe_n)
        else $error("data bus driven with output disabled");
    a_read_drive: assert property (boot_mode_supply_pin && !chip_select_n
        && !output_enable_n && write_strobe_n |=> !data_bus_oe_n)
        else $error("data bus not driven in read");
    a_no_supply: assert property (!boot_mode_supply_pin |=> data_bus_oe_n)
        else $error("data bus driven without supply");
    a_ro_idle: assert property (!check_select && !busy |=> !busy)
        else $error("operation started in read-only mode");
    a_busy_cause: assert property (s_busy_start |-> $past(check_select)
        && $past(boot_mode_supply_pin))
        else $error("operation started without write mode");
    a_busy_hold: assert property (s_busy_start |-> busy[*8])
        else $error("operation ended too early");
    a_busy_bound: assert property (s_busy_start |-> ##[1:400] !busy)
        else $error("operation never ended");
endmodule

// [fpp_prog_model.sv]
// external parallel programmer model driving the port pins
`timescale 1ns/1ps
module fpp_prog_model (
    input  wire        clk,
    output reg         cs_n,
    output reg         oe_n,
    output reg         we_n,
    output reg  [16:0] addr,
    output reg  [7:0]  dq,
    input  wire [7:0]  dq_in,
    input  wire        dq_oe_n
);
    initial begin
        cs_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        addr = 17'h00000;
        dq   = 8'h00;
    end
    // address settled before fall, data before rise
    task wr(input [16:0] a, input [7:0] d);
        begin
            @(posedge clk) #1;
            cs_n = 1'b0;
            addr = a;
            dq   = d;
            repeat (2) @(posedge clk);
            #1 we_n = 1'b0;
            repeat (2) @(posedge clk);
            #1 we_n = 1'b1;
            repeat (2) @(posedge clk);
            #1 cs_n = 1'b1;
            dq = ~d;
        end
    endtask
    task rd(input [16:0] a, output [7:0] q, output q_oe_n);
        begin
            @(posedge clk) #1;
            cs_n = 1'b0;
            oe_n = 1'b0;
            addr = a;
            repeat (3) @(posedge clk);
            #1;
            q      = dq_in;
            q_oe_n = dq_oe_n;
            cs_n   = 1'b1;
            oe_n = 1'b1;
        end
    endtask
endmodule

// [tb_top.sv]
// self-checking testbench for the parallel program port
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    reg         clk, reset_n, supply, chk_sel, q_oe;
    reg  [7:0]  q;
    wire        cs_n, oe_n, we_n, dq_oe_n, busy;
    wire [16:0] addr;
    wire [7:0]  dq, dq_out;
    integer     mismatches = 0, compares = 0;
    fpp_prog_model u_prog (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .dq(dq), .dq_in(dq_out), .dq_oe_n(dq_oe_n));
    fpp_port #(.PROG_CYCLES(10), .ERASE_CYCLES(300)) u_dut (.clk(clk), .reset_n(reset_n),
        .boot_mode_supply_pin(supply), .check_select(chk_sel), .chip_select_n(cs_n),
        .output_enable_n(oe_n), .write_strobe_n(we_n), .address(addr), .data_bus_in(dq),
        .data_bus_out(dq_out), .data_bus_oe_n(dq_oe_n), .busy(busy));
    task results;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task t_prog(input [16:0] a, input [7:0] d);
        begin
            u_prog.wr(17'h00000, 8'h40);
            u_prog.wr(a, d);
            @(posedge clk) #1;
            `CHK(busy, 1'b1)
            repeat (20) @(posedge clk);
            `CHK(busy, 1'b0)
            u_prog.wr(17'h00000, 8'hc0);
            u_prog.rd(17'h00000, q, q_oe);
            `CHK(q, d)
        end
    endtask
    task t_ro;
        begin
            chk_sel = 1'b0;
            u_prog.wr(17'h00000, 8'h40);
            u_prog.wr(17'h00006, 8'h11);
            @(posedge clk) #1;
            `CHK(busy, 1'b0)
            chk_sel = 1'b1;
        end
    endtask
    task t_reads;
        begin
            u_prog.wr(17'h00000, 8'h00);
            u_prog.rd(17'h00005, q, q_oe);
            `CHK(q, 8'h5a)
            `CHK(q_oe, 1'b0)
            u_prog.wr(17'h00005, 8'ha0);
            u_prog.rd(17'h00000, q, q_oe);
            `CHK(q, 8'h5a)
        end
    endtask
    task t_erase(input abort);
        begin
            u_prog.wr(17'h00000, 8'h20);
            u_prog.wr(17'h00000, 8'h20);
            @(posedge clk) #1;
            `CHK(busy, 1'b1)
            if (abort) begin
                u_prog.wr(17'h00000, 8'hff);
                u_prog.wr(17'h00000, 8'hff);
                @(posedge clk) #1;
            end else repeat (320) @(posedge clk);
            `CHK(busy, 1'b0)
            if (!abort) begin
                u_prog.wr(17'h00005, 8'ha0);
                u_prog.rd(17'h00000, q, q_oe);
                `CHK(q, 8'hff)
            end
        end
    endtask
    task t_locked;
        begin
            u_prog.wr(17'h00000, 8'h40);
            u_prog.wr(17'h0ffff, 8'hfe);
            repeat (20) @(posedge clk);
            u_prog.wr(17'h00000, 8'h40);
            u_prog.wr(17'h00005, 8'h33);
            @(posedge clk) #1;
            `CHK(busy, 1'b0)
            u_prog.wr(17'h00000, 8'h00);
            u_prog.rd(17'h00005, q, q_oe);
            `CHK(q, 8'h00)
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        mismatches++;
        results;
    end
    initial begin
        reset_n = 1'b0;
        supply  = 1'b0;
        chk_sel = 1'b1;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        u_prog.rd(17'h00005, q, q_oe);
        `CHK(q_oe, 1'b1)
        supply = 1'b1;
        t_prog(17'h0ffff, 8'h00);
        t_ro;
        t_prog(17'h00005, 8'h5a);
        t_reads;
        // zero the location before the first erase
        t_prog(17'h00005, 8'h00);
        t_erase(1'b1);
        t_erase(1'b0);
        t_locked;
        results;
    end
endmodule
bind fpp_port fpp_port_properties #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) u_props (.clk(clk), .reset_n(reset_n),
    .boot_mode_supply_pin(boot_mode_supply_pin), .check_select(check_select),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .address(address), .data_bus_oe_n(data_bus_oe_n),
    .busy(busy));
